// [core/pin_change_params.svh]
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH

// Register addresses
`define ADDR_PA_RISE   4'h0
`define ADDR_PA_FALL   4'h1
`define ADDR_PA_FLAG   4'h2
`define ADDR_PB_RISE   4'h3
`define ADDR_PB_FALL   4'h4
`define ADDR_PB_FLAG   4'h5
`define ADDR_IRQ_STAT  4'h6
`define ADDR_IRQ_MASK  4'h7

// Implemented bit masks
`define PA_IMPL_MASK   8'h3B
`define PB_IMPL_MASK   8'hF0
`define PA_LOW_MASK    8'h03
`define IRQ_IMPL_MASK  8'h01

// Field positions
`define SHARED_FLAG_BIT 0

// Reset values
`define REG_RESET      8'h00
`define BIT_RESET      1'h0

`endif

// [core/pin_change_pkg.sv]
package pin_change_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] pa_rise;
    logic [7:0] pa_fall;
    logic [7:0] pa_flag;
    logic [7:0] pb_rise;
    logic [7:0] pb_fall;
    logic [7:0] pb_flag;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
  } core_state_t;

endpackage

// [core/edge_sampler.sv]
`timescale 1ns/1ps
`include "pin_change_params.svh"

module edge_sampler #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] rise_ev,
  output logic      [WIDTH-1:0] fall_ev
);

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] prev;
    logic [2:0]       warm;
  } sampler_state_t;

  sampler_state_t state_reg;
  sampler_state_t state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;
    state_next.warm  = {state_reg.warm[1:0], 1'h1};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Successive synchronized samples compared, held off until prev holds a real sample
  assign rise_ev = state_reg.sync2 & ~state_reg.prev & {WIDTH{state_reg.warm[2]}};
  assign fall_ev = ~state_reg.sync2 & state_reg.prev & {WIDTH{state_reg.warm[2]}};

endmodule // edge_sampler

// [core/pin_change_edge_detect.sv]
// Contract
// - Port A falling enable sets pin and shared flag
// - Port A flag set by enabled rise or fall
// - Every hardware pin flag set also sets shared flag
// - Flag reads one when set; writing zero clears it
// - Flags writable, hardware sets independently
// - Port B rising enable sets flags
// - Zero enable suppresses that edge
// - Unimplemented bits ignore writes, read zero
// - All bits reset to zero
// - Port A low pins idle while USB active
// - Enabled edge wakes device from sleep
// - Port B falling enable sets flags
`timescale 1ns/1ps
`include "pin_change_params.svh"

module pin_change_edge_detect (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire pin_change_pkg::reg_req_t  bus_req,
  input  wire logic [7:0]                porta_pins,
  input  wire logic [7:0]                portb_pins,
  input  wire logic                      usb_active,
  input  wire logic                      sleep_active,
  output logic [7:0]                     rdata,
  output logic                           irq,
  output logic                           wake
);

  //////////////////////////////////////////////////////////////////////////////
  // Register decode helpers

  function automatic logic [7:0] impl_mask(input logic [3:0] addr);
    unique case (addr)
      `ADDR_PA_RISE, `ADDR_PA_FALL, `ADDR_PA_FLAG: impl_mask = `PA_IMPL_MASK;
      `ADDR_PB_RISE, `ADDR_PB_FALL, `ADDR_PB_FLAG: impl_mask = `PB_IMPL_MASK;
      `ADDR_IRQ_STAT, `ADDR_IRQ_MASK:            impl_mask = `IRQ_IMPL_MASK;
      default:                                   impl_mask = `REG_RESET;
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input pin_change_pkg::core_state_t s,
                                          input logic [3:0] addr);
    logic [7:0] v;
    v = `REG_RESET;
    unique case (addr)
      `ADDR_PA_RISE:  v = s.pa_rise;
      `ADDR_PA_FALL:  v = s.pa_fall;
      `ADDR_PA_FLAG:  v = s.pa_flag;
      `ADDR_PB_RISE:  v = s.pb_rise;
      `ADDR_PB_FALL:  v = s.pb_fall;
      `ADDR_PB_FLAG:  v = s.pb_flag;
      `ADDR_IRQ_STAT: v = s.status;
      `ADDR_IRQ_MASK: v = s.mask;
      default:        v = `REG_RESET;
    endcase
    reg_read = v & impl_mask(addr);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Edge sampling

  logic [7:0] pa_rise_ev;
  logic [7:0] pa_fall_ev;
  logic [7:0] pb_rise_ev;
  logic [7:0] pb_fall_ev;

  edge_sampler #(
    .WIDTH (8)
  ) u_porta_sampler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    (porta_pins),
    .rise_ev (pa_rise_ev),
    .fall_ev (pa_fall_ev)
  );

  edge_sampler #(
    .WIDTH (8)
  ) u_portb_sampler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    (portb_pins),
    .rise_ev (pb_rise_ev),
    .fall_ev (pb_fall_ev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Flag set terms

  pin_change_pkg::core_state_t state_reg;
  pin_change_pkg::core_state_t state_next;

  logic [7:0] pa_avail;
  logic [7:0] pa_hit_rise;
  logic [7:0] pa_hit_fall;
  logic [7:0] pa_set;
  logic [7:0] pb_hit_rise;
  logic [7:0] pb_hit_fall;
  logic [7:0] pb_set;
  logic       any_set;

  // Low pins lose their input buffer to USB
  assign pa_avail    = usb_active ? (`PA_IMPL_MASK & ~`PA_LOW_MASK) : `PA_IMPL_MASK;
  assign pa_hit_rise = pa_rise_ev & state_reg.pa_rise & pa_avail;
  assign pa_hit_fall = pa_fall_ev & state_reg.pa_fall & pa_avail;
  assign pa_set      = pa_hit_rise | pa_hit_fall;
  assign pb_hit_rise = pb_rise_ev & state_reg.pb_rise & `PB_IMPL_MASK;
  assign pb_hit_fall = pb_fall_ev & state_reg.pb_fall & `PB_IMPL_MASK;
  assign pb_set      = pb_hit_rise | pb_hit_fall;
  assign any_set     = (|pa_set) | (|pb_set);

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [7:0] wmask;

  always_comb begin
    state_next = state_reg;
    wmask      = impl_mask(bus_req.addr);
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ADDR_PA_RISE:  state_next.pa_rise = bus_req.wdata & wmask;
        `ADDR_PA_FALL:  state_next.pa_fall = bus_req.wdata & wmask;
        `ADDR_PA_FLAG:  state_next.pa_flag = bus_req.wdata & wmask;
        `ADDR_PB_RISE:  state_next.pb_rise = bus_req.wdata & wmask;
        `ADDR_PB_FALL:  state_next.pb_fall = bus_req.wdata & wmask;
        `ADDR_PB_FLAG:  state_next.pb_flag = bus_req.wdata & wmask;
        `ADDR_IRQ_STAT: state_next.status  = state_reg.status & ~(bus_req.wdata & wmask);
        `ADDR_IRQ_MASK: state_next.mask    = bus_req.wdata & wmask;
        default: ;
      endcase
    end
    // Hardware set wins over a software clear
    state_next.pa_flag = state_next.pa_flag | pa_set;
    state_next.pb_flag = state_next.pb_flag | pb_set;
    state_next.status[`SHARED_FLAG_BIT] = state_next.status[`SHARED_FLAG_BIT] | any_set;
    // Read data stand one cycle only
    state_next.rdata = bus_req.rd ? reg_read(state_reg, bus_req.addr) : `REG_RESET;
    state_next.irq   = |(state_next.status & state_next.mask);
    // Wake while asleep with enabled pending change
    state_next.wake  = sleep_active & state_next.mask[`SHARED_FLAG_BIT]
                       & state_next.status[`SHARED_FLAG_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign irq   = state_reg.irq;
  assign wake  = state_reg.wake;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_pa_fall_sets;
    @(posedge sys_clk) disable iff (rst)
      (pa_hit_fall != 8'h00) |=> ((state_reg.pa_flag & $past(pa_hit_fall)) == $past(pa_hit_fall));
  endproperty
  a_pa_fall_sets: assert property (p_pa_fall_sets) else $error("falling edge did not set flag");

  property p_pa_rise_sets;
    @(posedge sys_clk) disable iff (rst)
      (pa_hit_rise != 8'h00) |=> ((state_reg.pa_flag & $past(pa_hit_rise)) == $past(pa_hit_rise));
  endproperty
  a_pa_rise_sets: assert property (p_pa_rise_sets) else $error("rising edge did not set flag");

  property p_shared_set;
    @(posedge sys_clk) disable iff (rst)
      any_set |=> state_reg.status[`SHARED_FLAG_BIT] && (irq == state_reg.mask[`SHARED_FLAG_BIT]);
  endproperty
  a_shared_set: assert property (p_shared_set) else $error("shared flag not set");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.wr && bus_req.addr == `ADDR_PA_FLAG && bus_req.wdata == 8'h00 && pa_set == 8'h00)
      |=> (state_reg.pa_flag == 8'h00);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("zero write did not clear flags");

  property p_flag_readback;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr == `ADDR_PA_FLAG) |=> (rdata == $past(state_reg.pa_flag))
      ##1 ($past(bus_req.rd) || rdata == 8'h00);
  endproperty
  a_flag_readback: assert property (p_flag_readback) else $error("flag read data wrong");

  property p_pb_rise_sets;
    @(posedge sys_clk) disable iff (rst)
      (pb_hit_rise != 8'h00) |=> ((state_reg.pb_flag & $past(pb_hit_rise)) == $past(pb_hit_rise));
  endproperty
  a_pb_rise_sets: assert property (p_pb_rise_sets) else $error("port B rise did not set flag");

  property p_disabled_quiet;
    @(posedge sys_clk) disable iff (rst)
      (state_reg.pa_rise == 8'h00 && state_reg.pa_fall == 8'h00 && !bus_req.wr)
      |=> $stable(state_reg.pa_flag);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pin set a flag");

  property p_unimpl_zero;
    @(posedge sys_clk) disable iff (rst)
      ((state_reg.pa_flag | state_reg.pa_fall | state_reg.pa_rise) & ~`PA_IMPL_MASK) == 8'h00
      && ((state_reg.pb_flag | state_reg.pb_rise | state_reg.pb_fall) & ~`PB_IMPL_MASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit is set");

  property p_reset_clear;
    @(posedge sys_clk) rst |=> (state_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

  property p_usb_blocks;
    @(posedge sys_clk) disable iff (rst)
      usb_active |-> ((pa_set & `PA_LOW_MASK) == 8'h00);
  endproperty
  a_usb_blocks: assert property (p_usb_blocks) else $error("low pin detected under USB");

  property p_wake;
    @(posedge sys_clk) disable iff (rst)
      (sleep_active && state_reg.mask[`SHARED_FLAG_BIT] && any_set
       && !(bus_req.wr && bus_req.addr == `ADDR_IRQ_MASK)) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled edge did not wake");

  property p_pb_fall_sets;
    @(posedge sys_clk) disable iff (rst)
      (pb_hit_fall != 8'h00) |=> ((state_reg.pb_flag & $past(pb_hit_fall)) == $past(pb_hit_fall));
  endproperty
  a_pb_fall_sets: assert property (p_pb_fall_sets) else $error("port B fall did not set flag");

  property p_edges_exclusive;
    @(posedge sys_clk) disable iff (rst)
      ((pa_rise_ev & pa_fall_ev) == 8'h00) && ((pb_rise_ev & pb_fall_ev) == 8'h00);
  endproperty
  a_edges_exclusive: assert property (p_edges_exclusive) else $error("rise and fall at once");

  property p_pa_quiet;
    @(posedge sys_clk) disable iff (rst)
      (pa_set == 8'h00 && !bus_req.wr) |=> $stable(state_reg.pa_flag);
  endproperty
  a_pa_quiet: assert property (p_pa_quiet) else $error("port A flag moved with no edge");

  property p_pb_quiet;
    @(posedge sys_clk) disable iff (rst)
      (pb_set == 8'h00 && !bus_req.wr) |=> $stable(state_reg.pb_flag);
  endproperty
  a_pb_quiet: assert property (p_pb_quiet) else $error("port B flag moved with no edge");

  property p_status_w1c;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.wr && bus_req.addr == `ADDR_IRQ_STAT && bus_req.wdata[`SHARED_FLAG_BIT] && !any_set)
      |=> !state_reg.status[`SHARED_FLAG_BIT];
  endproperty
  a_status_w1c: assert property (p_status_w1c) else $error("shared flag not cleared by one");

  property p_status_sticky;
    @(posedge sys_clk) disable iff (rst)
      (state_reg.status[`SHARED_FLAG_BIT] && !(bus_req.wr && bus_req.addr == `ADDR_IRQ_STAT))
      |=> state_reg.status[`SHARED_FLAG_BIT];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("shared flag dropped by itself");

  property p_irq_masked;
    @(posedge sys_clk) disable iff (rst)
      (!state_reg.mask[`SHARED_FLAG_BIT] && !(bus_req.wr && bus_req.addr == `ADDR_IRQ_MASK)) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked change raised irq");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (rst)
      !bus_req.rd |=> (rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  property p_pa_fall_readback;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr == `ADDR_PA_FALL) |=> (rdata == $past(state_reg.pa_fall));
  endproperty
  a_pa_fall_readback: assert property (p_pa_fall_readback) else $error("fall enable read wrong");

  property p_pb_rise_readback;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr == `ADDR_PB_RISE) |=> (rdata == $past(state_reg.pb_rise));
  endproperty
  a_pb_rise_readback: assert property (p_pb_rise_readback) else $error("port B rise read wrong");

  property p_pa_read_unimpl;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr <= `ADDR_PA_FLAG) |=> ((rdata & ~`PA_IMPL_MASK) == 8'h00);
  endproperty
  a_pa_read_unimpl: assert property (p_pa_read_unimpl) else $error("port A unused bit read one");

  property p_pb_read_unimpl;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr >= `ADDR_PB_RISE && bus_req.addr <= `ADDR_PB_FLAG)
      |=> ((rdata & ~`PB_IMPL_MASK) == 8'h00);
  endproperty
  a_pb_read_unimpl: assert property (p_pb_read_unimpl) else $error("port B unused bit read one");

  property p_unmapped_read;
    @(posedge sys_clk) disable iff (rst)
      (bus_req.rd && bus_req.addr > `ADDR_IRQ_MASK) |=> (rdata == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped address read data");

  property p_wake_needs_sleep;
    @(posedge sys_clk) disable iff (rst)
      !sleep_active |=> !wake;
  endproperty
  a_wake_needs_sleep: assert property (p_wake_needs_sleep) else $error("wake while awake");

  property p_wake_needs_enable;
    @(posedge sys_clk) disable iff (rst)
      (!state_reg.mask[`SHARED_FLAG_BIT] && !(bus_req.wr && bus_req.addr == `ADDR_IRQ_MASK)) |=> !wake;
  endproperty
  a_wake_needs_enable: assert property (p_wake_needs_enable) else $error("wake with change irq off");

  property p_usb_free;
    @(posedge sys_clk) disable iff (rst)
      (!usb_active && (pa_fall_ev & state_reg.pa_fall & `PA_LOW_MASK) != 8'h00)
      |=> ((state_reg.pa_flag & `PA_LOW_MASK) != 8'h00);
  endproperty
  a_usb_free: assert property (p_usb_free) else $error("low pin missed without USB");

  property p_cv_pa_fall;
    @(posedge sys_clk) disable iff (rst) pa_hit_fall != 8'h00;
  endproperty
  c_pa_fall: cover property (p_cv_pa_fall);

  property p_cv_pb_rise;
    @(posedge sys_clk) disable iff (rst) pb_hit_rise != 8'h00;
  endproperty
  c_pb_rise: cover property (p_cv_pb_rise);

  property p_cv_clear_race;
    @(posedge sys_clk) disable iff (rst)
      bus_req.wr && bus_req.addr == `ADDR_PA_FLAG && pa_set != 8'h00;
  endproperty
  c_clear_race: cover property (p_cv_clear_race);

  property p_cv_wake;
    @(posedge sys_clk) disable iff (rst) wake;
  endproperty
  c_wake: cover property (p_cv_wake);

endmodule // pin_change_edge_detect

// [tb/pin_partner.sv]
`timescale 1ns/1ps

module pin_partner (
  input  wire logic       sys_clk,
  input  wire logic [7:0] want_a,
  input  wire logic [7:0] want_b,
  output logic      [7:0] porta_pins,
  output logic      [7:0] portb_pins
);
  ////////////////////////////////////////////////////////////////////////////
  // External pins move just after an edge and hold until asked again
  always_ff @(posedge sys_clk) begin
    porta_pins <= want_a;
    portb_pins <= want_b;
  end
endmodule // pin_partner

// [tb/pin_change_edge_detect_bench.sv]
`timescale 1ns/1ps
`include "pin_change_params.svh"

module pin_change_edge_detect_bench;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  pin_change_pkg::reg_req_t bus_req = '0;
  logic [7:0]               want_a = 8'h00;
  logic [7:0]               want_b = 8'h00;
  logic [7:0]               porta_pins;
  logic [7:0]               portb_pins;
  logic                     usb_active = 1'b0;
  logic                     sleep_active = 1'b0;
  logic [7:0]               rdata;
  logic                     irq;
  logic                     wake;
  logic [7:0]               m [0:7];
  logic [7:0]               cur_a = 8'h00;
  logic [7:0]               cur_b = 8'h00;
  int                       num_errors = 0;
  int                       samples_checked = 0;

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  pin_partner far_u (.sys_clk(sys_clk), .want_a(want_a), .want_b(want_b), .porta_pins(porta_pins),
                     .portb_pins(portb_pins));

  pin_change_edge_detect dut_u (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .porta_pins(porta_pins),
                                .portb_pins(portb_pins), .usb_active(usb_active), .sleep_active(sleep_active),
                                .rdata(rdata), .irq(irq), .wake(wake));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] impl(input int a);
    return (a >= 3 && a <= 5) ? `PB_IMPL_MASK : (a >= 6) ? `IRQ_IMPL_MASK : `PA_IMPL_MASK;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    bus_req <= '0;
    if (a < 4'h6) m[a] = d & impl(a);
    else if (a == 4'h6) m[6] = m[6] & ~(d & 8'h01);
    else if (a == 4'h7) m[7] = d & 8'h01;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    check($sformatf("reg %h", a), rdata, (a < 4'h8) ? m[a] : 8'h00);
    @(posedge sys_clk);
    #1;
    check("rdata idle", rdata, 8'h00);
  endtask

  task automatic check_all;
    for (int a = 0; a < 10; a++) rd(a[3:0]);
    check("irq", {7'h00, irq}, m[6] & m[7]);
    check("wake", {7'h00, wake}, m[6] & m[7] & {7'h00, sleep_active});
  endtask

  task automatic move_pins(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] hit_a;
    logic [7:0] hit_b;
    @(posedge sys_clk);
    want_a <= a;
    want_b <= b;
    repeat (7) @(posedge sys_clk);
    hit_a = ((a & ~cur_a & m[0]) | (~a & cur_a & m[1])) & `PA_IMPL_MASK;
    if (usb_active) hit_a = hit_a & ~`PA_LOW_MASK;
    hit_b = ((b & ~cur_b & m[3]) | (~b & cur_b & m[4])) & `PB_IMPL_MASK;
    m[2] = m[2] | hit_a;
    m[5] = m[5] | hit_b;
    if (hit_a != 8'h00 || hit_b != 8'h00) m[6] = 8'h01;
    cur_a = a;
    cur_b = b;
  endtask

  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) m[i] = 8'h00;
    cur_a = 8'h00;
    cur_b = 8'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(13130));
    for (int i = 0; i < 8; i++) m[i] = 8'h00;
    do_reset();
    check_all();
    $display("test reset values done");

    for (int a = 0; a < 16; a++) wr(a[3:0], 8'hFF);
    check_all();
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h01);
    check_all();
    $display("test register access done");

    for (int n = 0; n < 60; n++) begin
      for (int a = 0; a < 5; a++) if (a != 2) wr(a[3:0], 8'($urandom));
      wr(4'h7, 8'($urandom));
      @(posedge sys_clk);
      usb_active <= 1'($urandom);
      sleep_active <= 1'($urandom);
      move_pins(8'($urandom), 8'($urandom));
      check_all();
      wr(4'h2, m[2] & 8'($urandom));
      wr(4'h5, m[5] & 8'($urandom));
      wr(4'h6, 8'($urandom));
      check_all();
    end
    $display("test random edges done");

    wr(4'h0, 8'hFF);
    move_pins(8'hFF, 8'hF0);
    do_reset();
    usb_active <= 1'b0;
    sleep_active <= 1'b0;
    want_a <= 8'h00;
    want_b <= 8'h00;
    repeat (4) @(posedge sys_clk);
    check_all();
    $display("test second reset done");
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    $display("ERROR run length expected done seen hang");
    wrap_up();
  end
endmodule // pin_change_edge_detect_bench
